// ===== rtl/twc_defs.svh
// Constants shared by the two-wire controller files.
// Assumes inclusion by bare name from the rtl folder.
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

`define TWC_ADDR_W 7
`define TWC_BYTE_W 8
`define TWC_BIT_LAST 3'h7
`define TWC_BITS_PER_BYTE 4'h8
// Link clock cycles per quarter of a bus bit.
`define TWC_QUARTER_CYC 5
`define TWC_DIV_W 3

`endif

// ===== rtl/twc_pkg.sv
// Types of the two-wire controller: state encodings and carried words.
// Assumes twc_defs.svh is reachable on the include path.
`default_nettype none
`include "twc_defs.svh"

package twc_pkg;

	// Gray codes along the usual path of a master transfer, except M_STOP back to M_IDLE.
	typedef enum logic [2:0]
	{
		M_IDLE = 3'h0,
		M_START = 3'h1,
		M_BIT = 3'h3,
		M_ACK = 3'h2,
		M_STOP = 3'h6,
		M_WAIT_STOP = 3'h7
	} mst_state_t;

	typedef enum logic [2:0]
	{
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_AACK = 3'h3,
		S_DATA = 3'h2,
		S_DACK = 3'h6
	} slv_state_t;

	typedef struct packed
	{
		logic men;
		logic sen;
		logic [`TWC_ADDR_W-1:0] own_addr;
	} ctrl_t;

	typedef struct packed
	{
		logic [`TWC_ADDR_W-1:0] addr;
		logic [`TWC_BYTE_W-1:0] data;
	} xfer_t;

endpackage

`default_nettype wire

// ===== rtl/sync_2ff.sv
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// Destination domain
	input wire logic clk_i,
	input wire logic rst_i,
	// Level in and out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	always_comb
	begin
		meta_next = d_i;
		q_next = meta_reg;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_reg <= '0;
			q_reg <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			q_reg <= q_next;
		end
	end

	assign q_o = q_reg;
endmodule // sync_2ff

`default_nettype wire

// ===== rtl/pulse_xfer.sv
// Carries one-cycle events from one clock domain to another by a toggle.
// Assumes events are spaced by at least three destination cycles.
`timescale 1ns/1ps
`default_nettype none

module pulse_xfer (
	// Source domain
	input wire logic clk_src_i,
	input wire logic rst_src_i,
	input wire logic pulse_i,
	// Destination domain
	input wire logic clk_dst_i,
	input wire logic rst_dst_i,
	output logic pulse_o
);
	logic tog_reg;
	logic tog_next;
	logic tog_sync;
	logic last_reg;
	logic last_next;

	always_comb
	begin
		tog_next = tog_reg ^ pulse_i;
		last_next = tog_sync;
	end

	always_ff @(posedge clk_src_i or posedge rst_src_i)
	begin
		if (rst_src_i)
			tog_reg <= 1'b0;
		else
			tog_reg <= tog_next;
	end

	sync_2ff #(.WIDTH(1)) u_sync (
		.clk_i(clk_dst_i),
		.rst_i(rst_dst_i),
		.d_i(tog_reg),
		.q_o(tog_sync)
	);

	always_ff @(posedge clk_dst_i or posedge rst_dst_i)
	begin
		if (rst_dst_i)
			last_reg <= 1'b0;
		else
			last_reg <= last_next;
	end

	assign pulse_o = tog_sync ^ last_reg;
endmodule // pulse_xfer

`default_nettype wire

// ===== rtl/two_wire_controller.sv
// Multi-master two-wire controller: software side on clk_sys_i, bus engine
// on clk_link_i. Assumes open-drain pins resolved outside, pulled up high.
`timescale 1ns/1ps
`default_nettype none
`include "twc_defs.svh"

module two_wire_controller
	import twc_pkg::*;
(
	// Clocks and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic clk_link_i,
	// Software control
	input wire logic master_enable_bit_i,
	input wire logic master_disable_bit_i,
	input wire logic slave_enable_bit_i,
	input wire logic slave_disable_bit_i,
	input wire logic [`TWC_ADDR_W-1:0] own_slave_address_i,
	input wire logic [`TWC_ADDR_W-1:0] target_device_address_i,
	input wire logic [`TWC_BYTE_W-1:0] transmit_holding_register_i,
	input wire logic start_i,
	// Software status
	output logic arbitration_lost_flag_o,
	output logic transmission_complete_flag_o,
	output logic master_mode_o,
	output logic slave_mode_o,
	output logic [`TWC_BYTE_W-1:0] slave_rx_data_o,
	output logic slave_rx_valid_o,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o
);
	////////////////////////////////////////////////////////////////////////
	logic men_reg, men_next, sen_reg, sen_next;
	logic complete_reg, complete_next, arb_reg, arb_next;
	logic rx_valid_reg, rx_valid_next, start_ok;
	logic [`TWC_BYTE_W-1:0] rx_data_reg, rx_data_next, s_byte_reg;
	ctrl_t ctrl_reg, ctrl_next, ctrl_l;
	xfer_t xfer_reg, xfer_next;
	logic [2:0] ev_l, ev_sys;
	logic rst_link_meta_reg, rst_link_reg, req_l;

	always_comb
	begin
		men_next = men_reg;
		if (master_enable_bit_i)
			men_next = 1'b1;
		if (master_disable_bit_i)
			men_next = 1'b0;
		sen_next = sen_reg;
		if (slave_enable_bit_i)
			sen_next = 1'b1;
		if (slave_disable_bit_i)
			sen_next = 1'b0;
		ctrl_next = '{men: men_reg, sen: sen_reg, own_addr: own_slave_address_i};
		start_ok = start_i & complete_reg & men_reg;
		xfer_next = start_ok ? xfer_t'{addr: target_device_address_i,
			data: transmit_holding_register_i} : xfer_reg;
		// The completion and loss events win over the clear by a new start.
		complete_next = start_ok ? 1'b0 : complete_reg;
		if (ev_sys[0])
			complete_next = 1'b1;
		arb_next = start_ok ? 1'b0 : arb_reg;
		if (ev_sys[1])
			arb_next = 1'b1;
		rx_data_next = ev_sys[2] ? s_byte_reg : rx_data_reg;
		rx_valid_next = ev_sys[2];
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			men_reg <= 1'b0;
			sen_reg <= 1'b0;
			ctrl_reg <= '0;
			xfer_reg <= '0;
			complete_reg <= 1'b1;
			arb_reg <= 1'b0;
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
		end
		else
		begin
			men_reg <= men_next;
			sen_reg <= sen_next;
			ctrl_reg <= ctrl_next;
			xfer_reg <= xfer_next;
			complete_reg <= complete_next;
			arb_reg <= arb_next;
			rx_data_reg <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
		end
	end

	assign arbitration_lost_flag_o = arb_reg;
	assign transmission_complete_flag_o = complete_reg;
	assign master_mode_o = men_reg;
	assign slave_mode_o = sen_reg;
	assign slave_rx_data_o = rx_data_reg;
	assign slave_rx_valid_o = rx_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// Reset release is retimed to the link clock; assertion stays async.
	always_ff @(posedge clk_link_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rst_link_meta_reg <= 1'b1;
			rst_link_reg <= 1'b1;
		end
		else
		begin
			rst_link_meta_reg <= 1'b0;
			rst_link_reg <= rst_link_meta_reg;
		end
	end

	// Settings change only while idle, so a plain level sync is enough.
	sync_2ff #(.WIDTH($bits(ctrl_t))) u_ctrl_sync (
		.clk_i(clk_link_i),
		.rst_i(rst_link_reg),
		.d_i(ctrl_reg),
		.q_o(ctrl_l)
	);

	// The transfer word stays frozen from the start until completion.
	pulse_xfer u_req_xfer (
		.clk_src_i(clk_sys_i),
		.rst_src_i(rst_i),
		.pulse_i(start_ok),
		.clk_dst_i(clk_link_i),
		.rst_dst_i(rst_link_reg),
		.pulse_o(req_l)
	);

	for (genvar i = 0; i < 3; i++)
	begin : g_ev
		pulse_xfer u_ev_xfer (
			.clk_src_i(clk_link_i),
			.rst_src_i(rst_link_reg),
			.pulse_i(ev_l[i]),
			.clk_dst_i(clk_sys_i),
			.rst_dst_i(rst_i),
			.pulse_o(ev_sys[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	logic [1:0] pins_s;
	logic scl_s, sda_s, scl_d_reg, sda_d_reg, busy_reg, busy_next;
	logic start_det, stop_det, scl_rise, scl_fall, tick;

	sync_2ff #(.WIDTH(2)) u_pin_sync (
		.clk_i(clk_link_i),
		.rst_i(rst_link_reg),
		.d_i({scl_i, sda_i}),
		.q_o(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_comb
	begin
		start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
		stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
		scl_rise = scl_s & ~scl_d_reg;
		scl_fall = ~scl_s & scl_d_reg;
		busy_next = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_reg);
	end

	////////////////////////////////////////////////////////////////////////
	mst_state_t m_state_reg, m_state_next;
	logic [`TWC_DIV_W-1:0] div_reg, div_next;
	logic [1:0] q_reg, q_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [`TWC_BYTE_W-1:0] sh_reg, sh_next, data_reg, data_next;
	logic byte_idx_reg, byte_idx_next, pend_reg, pend_next, ack_reg, ack_next;
	logic m_scl_low_reg, m_scl_low_next, m_sda_low_reg, m_sda_low_next;
	logic lost_reg, lost_next, done_next, arb_ev_next;

	always_comb
	begin
		m_state_next = m_state_reg;
		q_next = q_reg;
		bit_cnt_next = bit_cnt_reg;
		byte_idx_next = byte_idx_reg;
		sh_next = sh_reg;
		data_next = data_reg;
		pend_next = pend_reg;
		ack_next = ack_reg;
		m_scl_low_next = m_scl_low_reg;
		m_sda_low_next = m_sda_low_reg;
		lost_next = stop_det ? 1'b0 : lost_reg;
		done_next = 1'b0;
		arb_ev_next = 1'b0;
		tick = (div_reg == '0);
		div_next = tick ? `TWC_DIV_W'(`TWC_QUARTER_CYC - 1) : div_reg - 1'b1;
		if (req_l)
		begin
			pend_next = 1'b1;
			sh_next = {xfer_reg.addr, 1'b0};
			data_next = xfer_reg.data;
		end
		case (m_state_reg)
			M_IDLE:
				if (tick && pend_reg && ctrl_l.men && !busy_reg)
				begin
					m_state_next = M_START;
					q_next = 2'h0;
				end
			M_START:
				if (tick && q_reg == 2'h0)
				begin
					// Another master won the race to the start: go back and wait.
					if (busy_reg)
						m_state_next = M_IDLE;
					else
					begin
						m_sda_low_next = 1'b1;
						q_next = 2'h1;
					end
				end
				else if (tick)
				begin
					m_scl_low_next = 1'b1;
					m_state_next = M_BIT;
					q_next = 2'h0;
					bit_cnt_next = `TWC_BIT_LAST;
					byte_idx_next = 1'b0;
					pend_next = 1'b0;
				end
			M_BIT:
				if (tick)
					case (q_reg)
						2'h0:
						begin
							m_scl_low_next = 1'b1;
							m_sda_low_next = ~sh_reg[7];
							q_next = 2'h1;
						end
						2'h1:
						begin
							m_scl_low_next = 1'b0;
							q_next = 2'h2;
						end
						2'h2:
							if (scl_s && !m_sda_low_reg && !sda_s)
							begin
								m_state_next = M_WAIT_STOP;
								m_sda_low_next = 1'b0;
								m_scl_low_next = 1'b0;
								lost_next = 1'b1;
								arb_ev_next = 1'b1;
							end
							else if (scl_s)
								q_next = 2'h3;
						default:
						begin
							q_next = 2'h0;
							m_scl_low_next = 1'b1;
							sh_next = {sh_reg[6:0], 1'b0};
							if (bit_cnt_reg == 3'h0)
								m_state_next = M_ACK;
							else
								bit_cnt_next = bit_cnt_reg - 3'h1;
						end
					endcase
			M_ACK:
				if (tick)
					case (q_reg)
						2'h0:
						begin
							m_sda_low_next = 1'b0;
							q_next = 2'h1;
						end
						2'h1:
						begin
							m_scl_low_next = 1'b0;
							q_next = 2'h2;
						end
						2'h2:
							if (scl_s)
							begin
								ack_next = ~sda_s;
								q_next = 2'h3;
							end
						default:
						begin
							m_scl_low_next = 1'b1;
							q_next = 2'h0;
							if (ack_reg && !byte_idx_reg)
							begin
								m_state_next = M_BIT;
								sh_next = data_reg;
								byte_idx_next = 1'b1;
								bit_cnt_next = `TWC_BIT_LAST;
							end
							else
								m_state_next = M_STOP;
						end
					endcase
			M_STOP:
				if (tick)
					case (q_reg)
						2'h0:
						begin
							m_sda_low_next = 1'b1;
							q_next = 2'h1;
						end
						2'h1:
						begin
							m_scl_low_next = 1'b0;
							q_next = 2'h2;
						end
						2'h2:
							if (scl_s)
								q_next = 2'h3;
						default:
						begin
							m_sda_low_next = 1'b0;
							q_next = 2'h0;
							m_state_next = M_IDLE;
							done_next = 1'b1;
						end
					endcase
			M_WAIT_STOP:
				if (stop_det)
				begin
					m_state_next = M_IDLE;
					done_next = 1'b1;
				end
			default:
				m_state_next = M_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	slv_state_t s_state_reg, s_state_next;
	logic [3:0] s_cnt_reg, s_cnt_next;
	logic [`TWC_BYTE_W-1:0] s_sh_reg, s_sh_next, s_byte_next;
	logic s_ack_reg, s_ack_next, rx_ev_next, addr_match;

	always_comb
	begin
		s_state_next = s_state_reg;
		s_cnt_next = s_cnt_reg;
		s_sh_next = s_sh_reg;
		s_byte_next = s_byte_reg;
		s_ack_next = s_ack_reg;
		rx_ev_next = 1'b0;
		addr_match = ctrl_l.sen && !lost_reg && !s_sh_reg[0] &&
			s_sh_reg[7:1] == ctrl_l.own_addr;
		if (start_det)
		begin
			s_state_next = S_ADDR;
			s_cnt_next = 4'h0;
			s_ack_next = 1'b0;
		end
		else if (stop_det)
		begin
			s_state_next = S_IDLE;
			s_ack_next = 1'b0;
		end
		else
			case (s_state_reg)
				S_ADDR, S_DATA:
					if (scl_rise && s_cnt_reg != `TWC_BITS_PER_BYTE)
					begin
						s_sh_next = {s_sh_reg[6:0], sda_s};
						s_cnt_next = s_cnt_reg + 4'h1;
					end
					else if (scl_fall && s_cnt_reg == `TWC_BITS_PER_BYTE)
					begin
						if (s_state_reg == S_DATA)
						begin
							s_state_next = S_DACK;
							s_ack_next = 1'b1;
							s_byte_next = s_sh_reg;
							rx_ev_next = 1'b1;
						end
						else if (addr_match)
						begin
							s_state_next = S_AACK;
							s_ack_next = 1'b1;
						end
						else
							s_state_next = S_IDLE;
					end
				S_AACK, S_DACK:
					if (scl_fall)
					begin
						s_state_next = S_DATA;
						s_ack_next = 1'b0;
						s_cnt_next = 4'h0;
					end
				default:
					s_state_next = S_IDLE;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	logic scl_oe_reg, sda_oe_reg, done_reg, arb_ev_reg, rx_ev_reg;

	always_ff @(posedge clk_link_i or posedge rst_link_reg)
	begin
		if (rst_link_reg)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			busy_reg <= 1'b0;
			m_state_reg <= M_IDLE;
			div_reg <= '0;
			q_reg <= 2'h0;
			bit_cnt_reg <= 3'h0;
			byte_idx_reg <= 1'b0;
			sh_reg <= '0;
			data_reg <= '0;
			pend_reg <= 1'b0;
			ack_reg <= 1'b0;
			m_scl_low_reg <= 1'b0;
			m_sda_low_reg <= 1'b0;
			lost_reg <= 1'b0;
			s_state_reg <= S_IDLE;
			s_cnt_reg <= 4'h0;
			s_sh_reg <= '0;
			s_byte_reg <= '0;
			s_ack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			done_reg <= 1'b0;
			arb_ev_reg <= 1'b0;
			rx_ev_reg <= 1'b0;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			busy_reg <= busy_next;
			m_state_reg <= m_state_next;
			div_reg <= div_next;
			q_reg <= q_next;
			bit_cnt_reg <= bit_cnt_next;
			byte_idx_reg <= byte_idx_next;
			sh_reg <= sh_next;
			data_reg <= data_next;
			pend_reg <= pend_next;
			ack_reg <= ack_next;
			m_scl_low_reg <= m_scl_low_next;
			m_sda_low_reg <= m_sda_low_next;
			lost_reg <= lost_next;
			s_state_reg <= s_state_next;
			s_cnt_reg <= s_cnt_next;
			s_sh_reg <= s_sh_next;
			s_byte_reg <= s_byte_next;
			s_ack_reg <= s_ack_next;
			scl_oe_reg <= m_scl_low_reg;
			sda_oe_reg <= m_sda_low_reg | s_ack_reg;
			done_reg <= done_next;
			arb_ev_reg <= arb_ev_next;
			rx_ev_reg <= rx_ev_next;
		end
	end

	assign ev_l = {rx_ev_reg, arb_ev_reg, done_reg};
	// Open-drain: the driven level is always low; the enable does the work.
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_reg;
	assign sda_oe_o = sda_oe_reg;

	////////////////////////////////////////////////////////////////////////
	sequence hi_bit_clash_s;
		m_state_reg == M_BIT && tick && q_reg == 2'h2 && scl_s && !m_sda_low_reg && !sda_s;
	endsequence
	sequence lost_wait_s;
		m_state_reg == M_WAIT_STOP && !stop_det;
	endsequence

	clash_loses_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		hi_bit_clash_s |=> m_state_reg == M_WAIT_STOP && lost_reg && arb_ev_reg)
		else $error("clash on released bit did not lose arbitration");
	loser_quiet_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		m_state_reg == M_WAIT_STOP |-> !m_sda_low_reg && !m_scl_low_reg)
		else $error("loser still drives the bus");
	wait_for_stop_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		lost_wait_s |=> m_state_reg == M_WAIT_STOP)
		else $error("loser left waiting before a stop");
	busy_defer_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		m_state_reg == M_IDLE && busy_reg |=> m_state_reg == M_IDLE)
		else $error("transfer began on a busy bus");
	master_gate_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		m_state_reg == M_IDLE && !ctrl_l.men |=> m_state_reg == M_IDLE)
		else $error("transfer began with master disabled");
	no_ack_lost_a: assert property (@(posedge clk_link_i) disable iff (rst_link_reg)
		s_state_reg == S_ADDR && lost_reg && !start_det && !stop_det |=> s_state_reg != S_AACK)
		else $error("own address acknowledged after lost arbitration");
	arb_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ev_sys[1] |=> arbitration_lost_flag_o ##1 arbitration_lost_flag_o || start_ok)
		else $error("arbitration lost flag not set");
	role_kept_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ev_sys[1] && !master_enable_bit_i && !master_disable_bit_i && !slave_enable_bit_i
		&& !slave_disable_bit_i |=> $stable(master_mode_o) && $stable(slave_mode_o))
		else $error("role changed on lost arbitration");
endmodule // two_wire_controller

`default_nettype wire

// ===== verification/bus_peer.sv
// Far side of the two-wire bus: a slave at SLV_ADDR that acknowledges
// writes, and a second master that can contend for the bus or keep it busy.
// Assumes scl_i and sda_i are the resolved wired-AND lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module bus_peer #(
	parameter logic [6:0] SLV_ADDR = 7'h55,
	parameter int H = 1000
) (
	// Resolved lines
	input wire logic scl_i,
	input wire logic sda_i,
	// Pull-downs, high holds the line low
	output var logic scl_low_o,
	output var logic sda_low_o
);
	logic m_sda_low = 1'b0;
	logic s_sda_low = 1'b0;
	logic smp;
	logic ack_seen;
	logic [7:0] got_addr = 8'h00;
	logic [7:0] got_data = 8'h00;

	assign sda_low_o = m_sda_low | s_sda_low;
	initial scl_low_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Master side. H is half a bit, long enough to outlast a late slave ack.
	task automatic m_bit(input logic b);
		m_sda_low = !b;
		#H scl_low_o = 1'b0;
		#H smp = sda_i;
		scl_low_o = 1'b1;
	endtask

	task automatic m_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			m_bit(b[i]);
		m_bit(1'b1);
	endtask

	task automatic m_start();
		m_sda_low = 1'b1;
		#H scl_low_o = 1'b1;
	endtask

	task automatic m_stop();
		m_sda_low = 1'b1;
		#H scl_low_o = 1'b0;
		#H m_sda_low = 1'b0;
		#H;
	endtask

	task automatic m_xfer(input logic [7:0] a, input logic [7:0] d);
		m_start();
		m_byte(a);
		ack_seen = smp;
		m_byte(d);
		m_stop();
	endtask

	// contend from start
	// Joins the other master's start, sends b[7] as its first bit and,
	// once the other side has backed off, clocks the rest of the byte itself.
	task automatic m_arb(input logic [7:0] b);
		@(negedge sda_i iff scl_i === 1'b1);
		m_sda_low = 1'b1;
		@(negedge scl_i);
		#100 m_sda_low = !b[7];
		@(posedge scl_i);
		#H scl_low_o = 1'b1;
		for (int i = 6; i >= 0; i--)
			m_bit(b[i]);
		m_bit(1'b1);
		ack_seen = smp;
		m_stop();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Slave side: acknowledges a write to SLV_ADDR and every byte after it.
	task automatic rx_frame();
		logic [7:0] b;
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < 64; n++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				@(posedge scl_i);
				b = {b[6:0], sda_i};
			end
			@(negedge scl_i);
			if (n == 0)
				hit = (b == {SLV_ADDR, 1'b0});
			if (hit && n == 0)
				got_addr = b;
			if (hit && n > 0)
				got_data = b;
			#200 s_sda_low = hit;
			@(negedge scl_i);
			#200 s_sda_low = 1'b0;
		end
	endtask

	initial
	begin
		forever
		begin
			@(negedge sda_i iff scl_i === 1'b1);
			fork
				@(posedge sda_i iff scl_i === 1'b1);
				rx_frame();
			join_any
			disable fork;
			s_sda_low = 1'b0;
		end
	end

endmodule // bus_peer
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the two-wire controller against bus_peer.
// Assumes the design and bus_peer are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "twc_defs.svh"

module testbench;
	localparam logic [6:0] PEER_ADDR = 7'h55;
	localparam logic [6:0] OWN_ADDR = 7'h2A;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rst = 1'b1;
	logic me = 1'b0;
	logic md = 1'b0;
	logic se = 1'b0;
	logic sd = 1'b0;
	logic start = 1'b0;
	logic [`TWC_ADDR_W-1:0] own = OWN_ADDR;
	logic [`TWC_ADDR_W-1:0] tgt = 7'h00;
	logic [`TWC_BYTE_W-1:0] tx_byte = 8'h00;
	logic lost, done, mmode, smode, rx_valid;
	logic [`TWC_BYTE_W-1:0] rx_data;
	logic scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
	int checked = 0;
	int miscompares = 0;
	int drove = 0;
	int rx_cnt = 0;
	int d0, r0;
	wire logic scl_w = ~((scl_oe & ~scl_o) | p_scl);
	wire logic sda_w = ~((sda_oe & ~sda_o) | p_sda);

	two_wire_controller two_wire_controller_i (.clk_sys_i(clk_sys), .rst_i(rst),
		.clk_link_i(clk_link), .master_enable_bit_i(me), .master_disable_bit_i(md),
		.slave_enable_bit_i(se), .slave_disable_bit_i(sd), .own_slave_address_i(own),
		.target_device_address_i(tgt), .transmit_holding_register_i(tx_byte),
		.start_i(start), .arbitration_lost_flag_o(lost),
		.transmission_complete_flag_o(done), .master_mode_o(mmode),
		.slave_mode_o(smode), .slave_rx_data_o(rx_data), .slave_rx_valid_o(rx_valid),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
		.sda_o(sda_o), .sda_oe_o(sda_oe));

	bus_peer #(.SLV_ADDR(PEER_ADDR), .H(1000)) bus_peer_i (.scl_i(scl_w),
		.sda_i(sda_w), .scl_low_o(p_scl), .sda_low_o(p_sda));

	initial forever #5 clk_sys = ~clk_sys;
	initial
	begin
		#37;
		forever #62.5 clk_link = ~clk_link;
	end

	// Counts cycles in which the design pulls a line, and received bytes.
	always @(posedge clk_sys)
	begin
		if (scl_oe !== 1'b0 || sda_oe !== 1'b0)
			drove <= drove + 1;
		if (rx_valid === 1'b1)
			rx_cnt <= rx_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	// Pulses {master enable, master disable, slave enable, slave disable}.
	task automatic ctl(input logic [3:0] v);
		@(posedge clk_sys);
		{me, md, se, sd} <= v;
		@(posedge clk_sys);
		{me, md, se, sd} <= 4'h0;
	endtask

	task automatic go(input logic [6:0] t, input logic [7:0] d);
		@(posedge clk_sys);
		tgt <= t;
		tx_byte <= d;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wait_for(input logic arb);
		int n = 0;
		while (((arb ? lost : done) !== 1'b1) && n < 20000)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk("flag wait timeout", 8'h00, (n == 20000) ? 8'h01 : 8'h00);
	endtask

	// The whole run is about 215 us; the limit leaves ample margin.
	initial
	begin
		#900_000;
		miscompares++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk_link);
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (60) @(posedge clk_sys);
		chk("reset state", 8'h40, {1'b0, done, lost, mmode, smode, scl_oe, sda_oe, rx_valid});
		d0 = drove;
		go(PEER_ADDR, 8'h11);
		repeat (200) @(posedge clk_sys);
		chk("start without master", 8'h80, {done, 7'(drove - d0)}); // refused
		ctl(4'b1000); // master role
		bus_peer_i.m_start();
		go(PEER_ADDR, 8'hA5); // start and data
		d0 = drove;
		bus_peer_i.m_byte(8'h20);
		chk("held while busy", 8'h00, {done, 7'(drove - d0)}); // deferred
		bus_peer_i.m_stop();
		wait_for(1'b0); // sent after stop
		chk("peer address", {PEER_ADDR, 1'b0}, bus_peer_i.got_addr); // transfer
		chk("peer data", 8'hA5, bus_peer_i.got_data); // transfer
		chk("no loss", 8'h00, lost); // no false loss
		for (int k = 0; k < 2; k++)
		begin
			if (k == 1)
				ctl(4'b0010); // master and slave
			fork
				bus_peer_i.m_arb({OWN_ADDR, 1'b0});
			join_none
			go(7'h55, 8'hFF); // contended start
			wait_for(1'b1); // loss detected
			chk("done during loss", 8'h00, done); // waits stop
			repeat (40) @(posedge clk_sys);
			d0 = drove;
			r0 = rx_cnt;
			wait_for(1'b0); // stop seen
			chk("released after loss", 8'h00, 8'(drove - d0)); // stays off
			chk("own ack after loss", 8'h01, bus_peer_i.ack_seen); // no ack
			chk("rx after loss", 8'h00, 8'(rx_cnt - r0)); // no byte
			chk("loss flag", 8'h01, lost); // flag set
			chk("roles kept", k ? 8'h03 : 8'h02, {6'h00, mmode, smode}); // no switch
			repeat (200) @(posedge clk_sys);
		end
		ctl(4'b0110); // slave role
		r0 = rx_cnt;
		bus_peer_i.m_xfer({OWN_ADDR, 1'b0}, 8'h3C); // address resent
		chk("own ack", 8'h00, bus_peer_i.ack_seen); // acked now
		chk("rx data", 8'h3C, rx_data); // slave access
		chk("rx pulse", 8'h01, (rx_cnt != r0) ? 8'h01 : 8'h00); // slave access
		chk("slave role", 8'h01, {6'h00, mmode, smode}); // roles set
		wait_for(1'b0); // complete first
		ctl(4'b1001); // master role
		go(PEER_ADDR, 8'hC3); // restart
		chk("loss cleared", 8'h00, lost); // new transfer
		wait_for(1'b0); // restart done
		chk("restart data", 8'hC3, bus_peer_i.got_data); // new byte
		summarize();
	end

endmodule // testbench
`default_nettype wire
